// File: src/mrc_pkg.sv
// package: encodings, field layouts and level codes of the region register block
package mrc_pkg;
  localparam int NUM_HYP_REGIONS_DEF = 16;
  localparam int NUM_KRN_REGIONS_DEF = 16;
  localparam int DIRECT_MAX          = 32;
  localparam logic [3:0] COPROC_NUM  = 4'h000f;
  localparam logic [3:0] CRN_REGION  = 4'h0006;
  localparam logic [3:0] CRN_IDENT   = 4'h0000;
  localparam logic [2:0] OPC1_HYP    = 3'h0004;
  localparam logic [2:0] OPC1_KRN    = 3'h0000;
  localparam logic [1:0] OPC1_DIR_HI = 2'h0002;
  localparam logic [3:0] CRM_SEL     = 4'h0002;
  localparam logic [3:0] CRM_IND     = 4'h0003;
  localparam logic [3:0] CRM_IDENT   = 4'h0000;
  localparam logic [2:0] OPC2_SEL    = 3'h0001;
  localparam logic [2:0] OPC2_BASE   = 3'h0000;
  localparam logic [2:0] OPC2_LIMIT  = 3'h0001;
  localparam logic [2:0] OPC2_IDENT  = 3'h0004;
  localparam logic [1:0] OPC2_DIR_LIM = 2'h0001;
  localparam logic       CRM_DIR_HI  = 1'h1;
  localparam int ADDR_LSB  = 6;
  localparam int SEL_W     = 8;
  localparam int CNT_LSB   = 8;
  localparam int CNT_W     = 8;
  localparam logic [5:0] LIMIT_LOW_ONES = 6'h003f;
  localparam logic [1:0] LVL_USER   = 2'h0000;
  localparam logic [1:0] LVL_KERNEL = 2'h0001;
  localparam logic [1:0] LVL_HYP    = 2'h0002;
  localparam logic [2:0] ATTR_HIGH_MIN = 3'h0004;
  localparam logic [1:0] SH_NONE  = 2'h0000;
  localparam logic [1:0] SH_OUTER = 2'h0002;
  localparam logic [1:0] SH_INNER = 2'h0003;
  typedef logic [31:0] mrc_word_t;
  // limit register storage: limit, attribute index, enable
  typedef struct packed {
    logic [25:0] limit;
    logic [2:0]  attrIdx;
    logic        enable;
  } mrc_limit_s;
  // base register storage: base, coherence domain, access perm, no execute
  typedef struct packed {
    logic [25:0] base;
    logic [1:0]  coherence;
    logic [1:0]  accessPerm;
    logic        noExecute;
  } mrc_base_s;
endpackage

// File: src/mrc_decode_if.sv
// interface: decoded coprocessor access between top and decoder
`timescale 1ns/1ps
`default_nettype none
interface mrc_decode_if;
  logic       valid;
  logic [2:0] opc1;
  logic [2:0] opc2;
  logic [3:0] crn;
  logic [3:0] crm;
  logic [3:0] coproc;
  logic       hitSel;
  logic       hitHypInd;
  logic       hitHypDir;
  logic       hitIdent;
  logic       hitKrnBase;
  logic [4:0] dirRegion;
  modport dec (input valid, opc1, opc2, crn, crm, coproc,
               output hitSel, hitHypInd, hitHypDir, hitIdent, hitKrnBase, dirRegion);
  modport top (output valid, opc1, opc2, crn, crm, coproc,
               input hitSel, hitHypInd, hitHypDir, hitIdent, hitKrnBase, dirRegion);
endinterface
`default_nettype wire

// File: src/mrc_decode.sv
// module: coprocessor encoding decoder for region registers
`timescale 1ns/1ps
`default_nettype none
module mrc_decode
(
  mrc_decode_if.dec d
);
  logic base;
  always_comb
  begin
    base = d.valid && d.coproc == mrc_pkg::COPROC_NUM;
    d.hitSel = base && d.crn == mrc_pkg::CRN_REGION && d.opc1 == mrc_pkg::OPC1_HYP
               && d.crm == mrc_pkg::CRM_SEL && d.opc2 == mrc_pkg::OPC2_SEL;
    d.hitHypInd = base && d.crn == mrc_pkg::CRN_REGION && d.opc1 == mrc_pkg::OPC1_HYP
                  && d.crm == mrc_pkg::CRM_IND && d.opc2 == mrc_pkg::OPC2_LIMIT;
    d.hitHypDir = base && d.crn == mrc_pkg::CRN_REGION && d.opc1[2:1] == mrc_pkg::OPC1_DIR_HI
                  && d.crm[3] == mrc_pkg::CRM_DIR_HI
                  && d.opc2[1:0] == mrc_pkg::OPC2_DIR_LIM;
    d.dirRegion = {d.opc1[0], d.crm[2:0], d.opc2[2]};
    d.hitIdent = base && d.crn == mrc_pkg::CRN_IDENT && d.opc1 == mrc_pkg::OPC1_KRN
                 && d.crm == mrc_pkg::CRM_IDENT && d.opc2 == mrc_pkg::OPC2_IDENT;
    d.hitKrnBase = base && d.crn == mrc_pkg::CRN_REGION && d.opc1 == mrc_pkg::OPC1_KRN
                   && d.crm == mrc_pkg::CRM_IND && d.opc2 == mrc_pkg::OPC2_BASE;
  end
endmodule
`default_nettype wire

// File: src/mrc_region_regs.sv
// module: protection region configuration system registers
// ****************************************
// ****************************************
`timescale 1ns/1ps
`default_nettype none
module mrc_region_regs
#(
  parameter int NUM_HYP_REGIONS = mrc_pkg::NUM_HYP_REGIONS_DEF,
  parameter int NUM_KRN_REGIONS = mrc_pkg::NUM_KRN_REGIONS_DEF,
  parameter logic HYP_PRESENT   = 1'h1
)
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // coprocessor access
  input  wire logic                   accValid,
  input  wire logic                   accWrite,
  input  wire logic [3:0]             accCoproc,
  input  wire logic [2:0]             accOpc1,
  input  wire logic [2:0]             accOpc2,
  input  wire logic [3:0]             accCrn,
  input  wire logic [3:0]             accCrm,
  input  wire logic [1:0]             accLevel,
  input  wire mrc_pkg::mrc_word_t     accWdata,
  // trap controls
  input  wire logic                   trapGroupZero,
  input  wire logic                   trapGroupSix,
  input  wire logic                   trapGroupTen,
  input  wire logic                   idGroupOneTrap,
  // kernel selector from neighbouring block
  input  wire logic [7:0]             kernelRegionSelector,
  // answer
  output logic                        rspValid,
  output mrc_pkg::mrc_word_t          rspRdata,
  output logic                        rspTrapHyp,
  output logic                        rspUndef,
  // region view for the matching datapath
  output logic [NUM_HYP_REGIONS-1:0]  hypRegionEnable,
  output logic [5:0]                  selAttrIndex,
  output logic                        selAttrFromHigh,
  output mrc_pkg::mrc_word_t          selLimitAddr,
  output mrc_pkg::mrc_word_t          krnSelBaseAddr,
  output logic [1:0]                  krnSelCoherence,
  output logic [1:0]                  krnSelAccessPerm
);
  localparam int HSEL_W = (NUM_HYP_REGIONS > 1) ? $clog2(NUM_HYP_REGIONS) : 1;
  localparam int KSEL_W = (NUM_KRN_REGIONS > 1) ? $clog2(NUM_KRN_REGIONS) : 1;
  localparam logic [7:0] KRN_COUNT = 8'(NUM_KRN_REGIONS);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic                          rspValid;
    mrc_pkg::mrc_word_t            rspRdata;
    logic                          rspTrapHyp;
    logic                          rspUndef;
    logic [HSEL_W-1:0]             hypSel;
    logic [NUM_HYP_REGIONS-1:0]    hypEn;
    logic [5:0]                    selAttr;
    logic                          selHigh;
    mrc_pkg::mrc_word_t            selLimit;
    mrc_pkg::mrc_word_t            kBase;
    logic [1:0]                    kSh;
    logic [1:0]                    kAp;
  } mrc_state_s;

  mrc_state_s stateFf;
  mrc_state_s nxtState;
  // field storage is unreset: only enables carry a defined value
  mrc_pkg::mrc_limit_s hypLimitFf [NUM_HYP_REGIONS];
  mrc_pkg::mrc_base_s  krnBaseFf  [NUM_KRN_REGIONS];

  mrc_decode_if dIf ();
  assign dIf.valid  = accValid;
  assign dIf.opc1   = accOpc1;
  assign dIf.opc2   = accOpc2;
  assign dIf.crn    = accCrn;
  assign dIf.crm    = accCrm;
  assign dIf.coproc = accCoproc;
  mrc_decode uDec (.d(dIf));

  // ****************************************
  // access check and register update
  // ****************************************
  logic               isKernel;
  logic               isHyp;
  logic               dirInRange;
  logic               hypWe;
  logic [HSEL_W-1:0]  hypIdx;
  logic               krnWe;
  logic [KSEL_W-1:0]  krnIdx;
  logic               anyHit;
  mrc_pkg::mrc_limit_s curLim;
  mrc_pkg::mrc_base_s  curBase;
  mrc_pkg::mrc_limit_s selLim;
  mrc_pkg::mrc_base_s  selBase;

  always_comb
  begin
    nxtState = stateFf;
    isKernel = accLevel == mrc_pkg::LVL_KERNEL;
    isHyp    = accLevel == mrc_pkg::LVL_HYP;
    dirInRange = 32'(dIf.dirRegion) < NUM_HYP_REGIONS;
    hypIdx   = dIf.hitHypDir ? HSEL_W'(dIf.dirRegion) : stateFf.hypSel;
    krnIdx   = KSEL_W'(kernelRegionSelector);
    curLim   = hypLimitFf[hypIdx];
    curBase  = krnBaseFf[krnIdx];
    hypWe    = 1'b0;
    krnWe    = 1'b0;
    anyHit   = dIf.hitSel || dIf.hitHypInd || (dIf.hitHypDir && dirInRange)
               || dIf.hitIdent || dIf.hitKrnBase;
    nxtState.rspValid   = accValid;
    nxtState.rspRdata   = '0;
    nxtState.rspTrapHyp = 1'b0;
    nxtState.rspUndef   = 1'b0;
    if (accValid)
    begin
      if (!anyHit || accLevel == mrc_pkg::LVL_USER)
        nxtState.rspUndef = 1'b1;
      else if (isKernel && HYP_PRESENT && dIf.hitHypDir && trapGroupTen)
        nxtState.rspTrapHyp = 1'b1;
      else if (isKernel && HYP_PRESENT && (dIf.hitSel || dIf.hitHypInd) && trapGroupSix)
        nxtState.rspTrapHyp = 1'b1;
      else if (isKernel && dIf.hitIdent && !accWrite && (trapGroupZero || idGroupOneTrap))
        nxtState.rspTrapHyp = 1'b1;
      else if (isKernel && (dIf.hitSel || dIf.hitHypInd || dIf.hitHypDir))
        nxtState.rspUndef = 1'b1;
      else if (dIf.hitSel)
      begin
        if (accWrite)
          nxtState.hypSel = accWdata[HSEL_W-1:0];
        nxtState.rspRdata[mrc_pkg::SEL_W-1:0] = mrc_pkg::SEL_W'(stateFf.hypSel);
      end
      else if (dIf.hitHypInd || dIf.hitHypDir)
      begin
        hypWe = accWrite;
        nxtState.rspRdata = {curLim.limit, 2'h0000, curLim.attrIdx, curLim.enable};
      end
      else if (dIf.hitIdent)
        nxtState.rspRdata[mrc_pkg::CNT_LSB +: mrc_pkg::CNT_W] = KRN_COUNT;
      else
      begin
        krnWe = accWrite;
        nxtState.rspRdata = {curBase.base, 1'b0, curBase.coherence,
                             curBase.accessPerm, curBase.noExecute};
      end
    end
    // enables mirror the limit registers so reset gives a clean 0
    if (hypWe)
      nxtState.hypEn[hypIdx] = accWdata[0];
    selLim  = hypLimitFf[stateFf.hypSel];
    selBase = krnBaseFf[krnIdx];
    nxtState.selAttr  = {3'h0000, selLim.attrIdx};
    nxtState.selHigh  = selLim.attrIdx >= mrc_pkg::ATTR_HIGH_MIN;
    nxtState.selLimit = {selLim.limit, mrc_pkg::LIMIT_LOW_ONES};
    nxtState.kBase    = {selBase.base, 6'h0000};
    // reserved coherence code 01 reported as non-shareable
    nxtState.kSh = (selBase.coherence == mrc_pkg::SH_OUTER
                    || selBase.coherence == mrc_pkg::SH_INNER)
                   ? selBase.coherence : mrc_pkg::SH_NONE;
    nxtState.kAp = selBase.accessPerm;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stateFf <= '0;
    else
      stateFf <= nxtState;
  end

  always_ff @(posedge clk)
  begin
    if (hypWe)
      hypLimitFf[hypIdx] <= '{limit: accWdata[31:mrc_pkg::ADDR_LSB],
                              attrIdx: accWdata[3:1], enable: accWdata[0]};
    if (krnWe)
      krnBaseFf[krnIdx] <= '{base: accWdata[31:mrc_pkg::ADDR_LSB],
                             coherence: accWdata[4:3], accessPerm: accWdata[2:1],
                             noExecute: accWdata[0]};
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rspValid         = stateFf.rspValid;
  assign rspRdata         = stateFf.rspRdata;
  assign rspTrapHyp       = stateFf.rspTrapHyp;
  assign rspUndef         = stateFf.rspUndef;
  assign hypRegionEnable  = stateFf.hypEn;
  assign selAttrIndex     = stateFf.selAttr;
  assign selAttrFromHigh  = stateFf.selHigh;
  assign selLimitAddr     = stateFf.selLimit;
  assign krnSelBaseAddr   = stateFf.kBase;
  assign krnSelCoherence  = stateFf.kSh;
  assign krnSelAccessPerm = stateFf.kAp;
endmodule
`default_nettype wire

// File: testbench/mrc_region_regs_asserts.sv
// checker: port-level properties of the region register block
`timescale 1ns/1ps
`default_nettype none
module mrc_region_regs_asserts
#(
  parameter int NUM_HYP_REGIONS = 16
)
(
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // access
  input wire logic                       accValid,
  input wire logic                       accWrite,
  input wire logic [3:0]                 accCoproc,
  input wire logic [2:0]                 accOpc1,
  input wire logic [2:0]                 accOpc2,
  input wire logic [3:0]                 accCrn,
  input wire logic [3:0]                 accCrm,
  input wire logic [1:0]                 accLevel,
  input wire logic                       trapGroupZero,
  input wire logic                       trapGroupSix,
  input wire logic                       trapGroupTen,
  input wire logic                       idGroupOneTrap,
  // answer and region view
  input wire logic                       rspTrapHyp,
  input wire logic                       rspUndef,
  input wire logic [NUM_HYP_REGIONS-1:0] hypRegionEnable,
  input wire logic [5:0]                 selAttrIndex,
  input wire logic                       selAttrFromHigh,
  input wire mrc_pkg::mrc_word_t         selLimitAddr,
  input wire mrc_pkg::mrc_word_t         krnSelBaseAddr
);
  logic       dirHit;
  logic       selHit;
  logic       cntHit;
  logic       krn;
  logic [4:0] dirIdx;
  assign dirHit = accValid && accCoproc == 4'hF && accCrn == 4'h6 && accOpc1[2:1] == 2'h2
                  && accCrm[3] && accOpc2[1:0] == 2'h1;
  assign dirIdx = {accOpc1[0], accCrm[2:0], accOpc2[2]};
  assign selHit = accValid && accCoproc == 4'hF && {accOpc1, accCrn, accCrm, accOpc2}
                  == {3'h4, 4'h6, 4'h2, 3'h1};
  assign cntHit = accValid && accCoproc == 4'hF && {accOpc1, accCrn, accCrm, accOpc2}
                  == {3'h0, 4'h0, 4'h0, 3'h4};
  assign krn = accLevel == mrc_pkg::LVL_KERNEL;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_user_no_access: assert property (accValid && accLevel == mrc_pkg::LVL_USER
    |=> rspUndef && !rspTrapHyp) else $error("user access not refused");
  a_dir_unallocated: assert property (dirHit && dirIdx >= NUM_HYP_REGIONS
    && accLevel == mrc_pkg::LVL_HYP |=> rspUndef) else $error("unallocated direct accepted");
  a_dir_trap_ten: assert property (dirHit && krn && dirIdx < NUM_HYP_REGIONS
    && trapGroupTen |=> rspTrapHyp && !rspUndef) else $error("direct limit not trapped");
  a_sel_trap_six: assert property (selHit && krn && trapGroupSix
    |=> rspTrapHyp) else $error("selector access not trapped");
  a_count_trap: assert property (cntHit && krn && !accWrite
    && (trapGroupZero || idGroupOneTrap) |=> rspTrapHyp) else $error("count read not trapped");
  a_count_kernel_ok: assert property (cntHit && krn && (accWrite
    || !(trapGroupZero || idGroupOneTrap)) |=> !rspTrapHyp && !rspUndef)
    else $error("count access refused");
  a_limit_low_ones: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3)
    |-> selLimitAddr[5:0] == 6'h3F) else $error("limit low bits not ones");
  a_base_low_zero: assert property (krnSelBaseAddr[5:0] == 6'h00)
    else $error("base low bits not zero");
  a_attr_high_table: assert property (selAttrIndex[2]
    |-> selAttrFromHigh && selAttrIndex[5:3] == 3'h0) else $error("high table not chosen");
  a_enable_after_reset: assert property ($past(rst) |-> hypRegionEnable == '0)
    else $error("enables not cleared by reset");
endmodule
bind mrc_region_regs mrc_region_regs_asserts #(.NUM_HYP_REGIONS(NUM_HYP_REGIONS)) u_chk (.*);
`default_nettype wire

// File: testbench/mrc_region_regs_tb.sv
// testbench: coprocessor access sequences for the region register block
`timescale 1ns/1ps
`default_nettype none
module mrc_region_regs_tb;
  logic clk, rst, accValid, accWrite, rspValid, rspTrapHyp, rspUndef, selAttrFromHigh;
  logic trapGroupZero, trapGroupSix, trapGroupTen, idGroupOneTrap, tp, ud;
  logic [3:0] accCoproc, accCrn, accCrm;
  logic [2:0] accOpc1, accOpc2;
  logic [1:0] accLevel, krnSelCoherence, krnSelAccessPerm, sh;
  logic [7:0] kernelRegionSelector;
  logic [5:0] selAttrIndex;
  logic [15:0] hypRegionEnable;
  mrc_pkg::mrc_word_t accWdata, rspRdata, selLimitAddr, krnSelBaseAddr, rd, b;
  int err_total, checked;
  localparam logic [13:0] SEL = {3'h4, 4'h6, 4'h2, 3'h1};
  localparam logic [13:0] IND = {3'h4, 4'h6, 4'h3, 3'h1};
  localparam logic [13:0] CNT = {3'h0, 4'h0, 4'h0, 3'h4};
  localparam logic [13:0] KB  = {3'h0, 4'h6, 4'h3, 3'h0};
  mrc_region_regs dut (.*);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************************************
  // access and compare tasks
  // ****************************************
  function automatic logic [13:0] dl(input logic [4:0] n);
    return {2'h2, n[4], 4'h6, 1'b1, n[3:1], n[0], 2'h1};
  endfunction
  function automatic mrc_pkg::mrc_word_t lim(input logic [4:0] n);
    return {6'h15, n, 15'h0000, 2'h0, n[2:0], n[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [1:0] lvl, input logic [13:0] enc,
                     input logic [31:0] wd);
    @(negedge clk);
    accValid = 1'b1;
    accWrite = w;
    accLevel = lvl;
    {accOpc1, accCrn, accCrm, accOpc2} = enc;
    accWdata = wd;
    @(negedge clk);
    accValid = 1'b0;
    chk("rspValid", 32'h0000_0001, {31'h0000_0000, rspValid});
    rd = rspRdata;
    tp = rspTrapHyp;
    ud = rspUndef;
  endtask
  task automatic res(input logic t, input logic u);
    chk("trap/undef", {30'h0000_0000, t, u}, {30'h0000_0000, tp, ud});
  endtask
  task automatic final_report;
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    final_report;
  end
  initial
  begin
    {rst, accValid, accWrite, accOpc1, accOpc2, accCrn, accCrm, accLevel} = {1'b1, 18'h0_0000};
    {trapGroupZero, trapGroupSix, trapGroupTen, idGroupOneTrap} = 4'h0;
    accCoproc = 4'hF;
    accWdata = 32'h0000_0000;
    kernelRegionSelector = 8'h02;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("enables", 32'h0000_0000, {16'h0000, hypRegionEnable});
    // regions past the implemented count must be refused
    for (int n = 0; n < 32; n++)
    begin
      acc(1'b1, mrc_pkg::LVL_HYP, dl(5'(n)), lim(5'(n)));
      res(1'b0, n >= 16);
    end
    for (int n = 0; n < 16; n++)
    begin
      acc(1'b0, mrc_pkg::LVL_HYP, dl(5'(n)), 32'h0000_0000);
      chk("direct limit", lim(5'(n)), rd);
    end
    chk("enables", 32'h0000_AAAA, {16'h0000, hypRegionEnable});
    // selector kept below the region count
    for (int s = 3; s < 6; s += 2)
    begin
      acc(1'b1, mrc_pkg::LVL_HYP, SEL, s);
      acc(1'b0, mrc_pkg::LVL_HYP, SEL, 32'h0000_0000);
      chk("selector", s, rd);
      acc(1'b0, mrc_pkg::LVL_HYP, IND, 32'h0000_0000);
      chk("indirect limit", lim(5'(s)), rd);
      repeat (2) @(negedge clk);
      chk("limit view", lim(5'(s)) | 32'h0000_003F, selLimitAddr);
      chk("attr view", {s[2], 3'h0, 3'h0, s[2:0]}, {selAttrFromHigh, 3'h0, selAttrIndex});
    end
    trapGroupTen = 1'b1;
    acc(1'b1, mrc_pkg::LVL_KERNEL, dl(5'd2), 32'h0000_0000);
    res(1'b1, 1'b0);
    trapGroupTen = 1'b0;
    acc(1'b1, mrc_pkg::LVL_KERNEL, dl(5'd2), 32'h0000_0000);
    res(1'b0, 1'b1);
    acc(1'b0, mrc_pkg::LVL_HYP, dl(5'd2), 32'h0000_0000);
    chk("kept limit", lim(5'd2), rd);
    trapGroupSix = 1'b1;
    acc(1'b1, mrc_pkg::LVL_KERNEL, SEL, 32'h0000_0000);
    res(1'b1, 1'b0);
    acc(1'b0, mrc_pkg::LVL_KERNEL, IND, 32'h0000_0000);
    res(1'b1, 1'b0);
    trapGroupSix = 1'b0;
    // without the trap the selector stays hypervisor only
    acc(1'b1, mrc_pkg::LVL_KERNEL, SEL, 32'h0000_0000);
    res(1'b0, 1'b1);
    acc(1'b0, mrc_pkg::LVL_HYP, SEL, 32'h0000_0000);
    chk("selector kept", 32'h0000_0005, rd);
    for (int t = 3; t >= 0; t--)
    begin
      {trapGroupZero, idGroupOneTrap} = t[1:0];
      acc(1'b0, mrc_pkg::LVL_KERNEL, CNT, 32'h0000_0000);
      res(t != 0, 1'b0);
    end
    chk("region count", 32'h0000_1000, rd);
    acc(1'b0, mrc_pkg::LVL_USER, CNT, 32'h0000_0000);
    res(1'b0, 1'b1);
    acc(1'b0, mrc_pkg::LVL_HYP, 14'h3FFF, 32'h0000_0000);
    res(1'b0, 1'b1);
    // every permission code, and each defined coherence code
    for (int i = 0; i < 4; i++)
    begin
      sh = {i != 0, i > 1};
      b = {8'h5A, 16'h0000, i[1:0], 1'b0, sh, i[1:0], 1'b1};
      acc(1'b1, i[0] ? mrc_pkg::LVL_HYP : mrc_pkg::LVL_KERNEL, KB, b);
      acc(1'b0, mrc_pkg::LVL_KERNEL, KB, 32'h0000_0000);
      chk("base", b, rd);
      repeat (2) @(negedge clk);
      chk("base view", {b[31:6], 6'h00}, krnSelBaseAddr);
      chk("domain/perm", {sh, i[1:0]}, {krnSelCoherence, krnSelAccessPerm});
    end
    acc(1'b0, mrc_pkg::LVL_USER, KB, 32'h0000_0000);
    res(1'b0, 1'b1);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk("enables after reset", 32'h0000_0000, {16'h0000, hypRegionEnable});
    final_report;
  end
endmodule
`default_nettype wire
